// ### sgs_cfg.svh
// Constants for the setting group selector
`ifndef SGS_CFG_SVH
`define SGS_CFG_SVH

// ----------------------------------------------------------------------
// Group, relay and overcurrent element counts
// ----------------------------------------------------------------------
`define SGS_NUM_GROUPS 4
`define SGS_NUM_RELAYS 5
`define SGS_NUM_OC 5

// ----------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------
`define SGS_GRP_DEFAULT 2'h0
`define SGS_EDIT_FOLLOW 3'h4
`define SGS_RELAY_RST 5'h00
`define SGS_CNT_RST 32'h0000_0000
`define SGS_CNT_ONE 32'h0000_0001

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SGS_CLK_KHZ 200000
`define SGS_FLASH_HALF_MS 250

`endif

// ### sgs_pkg.sv
// Types shared by the setting group selector files
package sgs_pkg;

  // Group index, 0 is group 1
  typedef logic [1:0] group_t;

  // Edit group choice
  typedef enum logic [2:0] {
    EDIT_G1 = 3'h0,
    EDIT_G2 = 3'h1,
    EDIT_G3 = 3'h2,
    EDIT_G4 = 3'h3,
    EDIT_FOLLOW = 3'h4
  } edit_sel_t;

endpackage : sgs_pkg

// ### sgs_req_if.sv
// Carrier for conditioned pin inputs between the selector's modules
`timescale 1ns/100ps

interface sgs_req_if #(
  parameter int NUM_GROUPS = 4
);
  logic [NUM_GROUPS-1:0] grp_req;
  logic brk_open;

  // Conditioner drives, core reads
  modport cond (
    output grp_req,
    output brk_open
  );
  modport core (
    input grp_req,
    input brk_open
  );
endinterface : sgs_req_if

// ### sgs_input_sync.sv
// Two-stage synchroniser for group request and breaker status pins
`timescale 1ns/100ps

module sgs_input_sync #(
  parameter int NUM_GROUPS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Raw pins
  input wire logic [NUM_GROUPS-1:0] grp_in_pin,
  input wire logic brk_open_pin,
  // Conditioned levels
  sgs_req_if.cond req
);

  // ----------------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------------
  logic [NUM_GROUPS:0] meta_r;
  logic [NUM_GROUPS:0] meta_nxt;
  logic [NUM_GROUPS:0] sync_r;
  logic [NUM_GROUPS:0] sync_nxt;

  // Stage one is read only by stage two; clk_en freezes both
  always_comb begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (clk_en) begin
      meta_nxt = {brk_open_pin, grp_in_pin};
      sync_nxt = meta_r;
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  // Level requests, sampled on each clock with clk_en high
  assign req.grp_req = sync_r[NUM_GROUPS-1:0];
  assign req.brk_open = sync_r[NUM_GROUPS];

endmodule : sgs_input_sync

// ### setting_group_selector.sv
// Active and edit setting group selection with change inhibit
`timescale 1ns/100ps
`include "sgs_cfg.svh"

module setting_group_selector #(
  parameter int NUM_GROUPS = `SGS_NUM_GROUPS,
  parameter int NUM_RELAYS = `SGS_NUM_RELAYS,
  parameter int NUM_OC = `SGS_NUM_OC,
  parameter int unsigned FLASH_HALF_CYC =
    `SGS_FLASH_HALF_MS * (`SGS_CLK_KHZ)
) (
  // Clock, reset and clock enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Group selection settings
  input wire logic [1:0] cfg_active_group,
  input wire logic [2:0] cfg_edit_sel,
  // Inhibit source enables
  input wire logic en_inh_open_brk,
  input wire logic en_inh_oc,
  input wire logic en_inh_ov,
  input wire logic en_inh_uv,
  input wire logic en_inh_uf,
  // Logic input pins and breaker status pin
  input wire logic [NUM_GROUPS-1:0] grp_in_pin,
  input wire logic brk_open_pin,
  // Overcurrent elements: phase, neutral, ground, sens ground, neg seq
  input wire logic [NUM_OC-1:0] oc_pickup,
  input wire logic [NUM_OC-1:0] oc_func_on,
  // Overvoltage element
  input wire logic ov_pickup,
  input wire logic ov_func_on,
  // Bus and line undervoltage elements
  input wire logic uv_bus_pickup,
  input wire logic uv_bus_func_on,
  input wire logic uv_line_pickup,
  input wire logic uv_line_func_on,
  // Underfrequency element
  input wire logic uf_pickup,
  input wire logic uf_func_on,
  // Per-group aux relay selection
  input wire logic [NUM_GROUPS-1:0][NUM_RELAYS-1:0] grp_relay_sel,
  // Group state
  output logic [1:0] active_group,
  output logic [1:0] edit_group,
  output logic [NUM_RELAYS-1:0] aux_relay_sel,
  // Indicators
  output logic [NUM_GROUPS-1:0] grp_led,
  // Status and event
  output logic change_inhibited,
  output logic change_pending,
  output logic grp_event,
  output logic [1:0] grp_event_group
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // Group index is two bits wide, so more than four groups cannot be named
  if (NUM_GROUPS < 2 || NUM_GROUPS > 4) begin : g_bad_groups
    $error("NUM_GROUPS must be 2 to 4");
  end
  if (NUM_RELAYS < 1) begin : g_bad_relays
    $error("NUM_RELAYS must be at least 1");
  end
  if (NUM_OC < 1) begin : g_bad_oc
    $error("NUM_OC must be at least 1");
  end
  // A zero half period would wrap the limit and stretch the flash phase to the full 32-bit count
  if (FLASH_HALF_CYC < 1) begin : g_bad_flash
    $error("FLASH_HALF_CYC must be at least 1");
  end

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------

  // One-hot form of a group index
  function automatic logic [NUM_GROUPS-1:0] grp_onehot(
    input sgs_pkg::group_t g
  );
    logic [NUM_GROUPS-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_GROUPS; i++) begin
      if (g == sgs_pkg::group_t'(i)) begin
        v[i] = 1'b1;
      end
    end
    return v;
  endfunction : grp_onehot

  // Highest set bit wins; bit 0 stands for group 1
  function automatic sgs_pkg::group_t grp_highest(
    input logic [NUM_GROUPS-1:0] v
  );
    sgs_pkg::group_t g;
    g = `SGS_GRP_DEFAULT;
    for (int i = 0; i < NUM_GROUPS; i++) begin
      if (v[i]) begin
        g = sgs_pkg::group_t'(i);
      end
    end
    return g;
  endfunction : grp_highest

  // ----------------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------------
  sgs_req_if #(.NUM_GROUPS(NUM_GROUPS)) req ();

  // Logic inputs are levels, sampled through two flops on each clock with clk_en high
  sgs_input_sync #(
    .NUM_GROUPS(NUM_GROUPS)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .grp_in_pin(grp_in_pin),
    .brk_open_pin(brk_open_pin),
    .req(req)
  );

  // ----------------------------------------------------------------------
  // Request resolution
  // ----------------------------------------------------------------------
  logic [NUM_GROUPS-1:0] req_vec;
  sgs_pkg::group_t req_best;

  // Group 1 is always requested so it holds when nothing else is
  always_comb begin
    req_vec = req.grp_req;
    req_vec = req_vec | grp_onehot(cfg_active_group);
    req_vec[0] = 1'b1;
    req_best = grp_highest(req_vec);
  end

  // ----------------------------------------------------------------------
  // Change inhibit
  // ----------------------------------------------------------------------
  logic oc_up;
  logic ov_up;
  logic uv_up;
  logic uf_up;
  logic inhibit;

  // Pickup counts whenever the element is not Disabled, trip or not
  always_comb begin
    oc_up = |(oc_pickup & oc_func_on);
    ov_up = ov_pickup & ov_func_on;
    uv_up = (uv_bus_pickup & uv_bus_func_on) |
            (uv_line_pickup & uv_line_func_on);
    uf_up = uf_pickup & uf_func_on;
    inhibit = (en_inh_oc & oc_up) | (en_inh_ov & ov_up) |
              (en_inh_uv & uv_up) | (en_inh_uf & uf_up);
    inhibit = inhibit | (en_inh_open_brk & req.brk_open);
  end

  // ----------------------------------------------------------------------
  // Active and edit group state
  // ----------------------------------------------------------------------
  sgs_pkg::group_t active_r;
  sgs_pkg::group_t active_nxt;
  sgs_pkg::group_t edit_r;
  sgs_pkg::group_t edit_nxt;
  logic evt_r;
  logic evt_nxt;
  sgs_pkg::group_t evt_grp_r;
  sgs_pkg::group_t evt_grp_nxt;
  logic [NUM_RELAYS-1:0] relay_r;
  logic [NUM_RELAYS-1:0] relay_nxt;
  logic inh_r;
  logic inh_nxt;
  logic pend_r;
  logic pend_nxt;

  // A blocked request is simply held off: since requests are levels, the
  // change lands as soon as every enabled inhibit has cleared
  always_comb begin
    active_nxt = active_r;
    edit_nxt = edit_r;
    evt_nxt = evt_r;
    evt_grp_nxt = evt_grp_r;
    relay_nxt = relay_r;
    inh_nxt = inh_r;
    pend_nxt = pend_r;
    if (clk_en) begin
      evt_nxt = 1'b0;
      if (req_best != active_r && !inhibit) begin
        active_nxt = req_best;
      end
      // Event on any move whose target is not the default group
      if (active_nxt != active_r &&
          active_nxt != sgs_pkg::group_t'(`SGS_GRP_DEFAULT)) begin
        evt_nxt = 1'b1;
        evt_grp_nxt = active_nxt;
      end
      // Edit group takes its setting for codes 0 to 3 and follows the new active group otherwise
      if (cfg_edit_sel == `SGS_EDIT_FOLLOW) begin
        edit_nxt = active_nxt;
      end else if (cfg_edit_sel < `SGS_EDIT_FOLLOW) begin
        edit_nxt = cfg_edit_sel[1:0];
      end else begin
        edit_nxt = active_nxt;
      end
      relay_nxt = grp_relay_sel[active_nxt];
      inh_nxt = inhibit;
      pend_nxt = (req_best != active_r) && inhibit;
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_r <= `SGS_GRP_DEFAULT;
      edit_r <= `SGS_GRP_DEFAULT;
      evt_r <= 1'b0;
      evt_grp_r <= `SGS_GRP_DEFAULT;
      relay_r <= `SGS_RELAY_RST;
      inh_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
      edit_r <= edit_nxt;
      evt_r <= evt_nxt;
      evt_grp_r <= evt_grp_nxt;
      relay_r <= relay_nxt;
      inh_r <= inh_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Flash timebase
  // ----------------------------------------------------------------------
  logic [31:0] flash_cnt_r;
  logic [31:0] flash_cnt_nxt;
  logic flash_on_r;
  logic flash_on_nxt;

  // Free-running half period; frozen with the rest while clk_en is low
  always_comb begin
    flash_cnt_nxt = flash_cnt_r;
    flash_on_nxt = flash_on_r;
    if (clk_en) begin
      if (flash_cnt_r >= FLASH_HALF_CYC - 1) begin
        flash_cnt_nxt = `SGS_CNT_RST;
        flash_on_nxt = !flash_on_r;
      end else begin
        flash_cnt_nxt = flash_cnt_r + `SGS_CNT_ONE;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_cnt_r <= `SGS_CNT_RST;
      flash_on_r <= 1'b0;
    end else begin
      flash_cnt_r <= flash_cnt_nxt;
      flash_on_r <= flash_on_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------------
  logic [NUM_GROUPS-1:0] led_r;
  logic [NUM_GROUPS-1:0] led_nxt;

  // Active steady wins over edit flashing on the same group
  always_comb begin
    led_nxt = led_r;
    if (clk_en) begin
      led_nxt = grp_onehot(active_nxt) |
                (grp_onehot(edit_nxt) & {NUM_GROUPS{flash_on_nxt}});
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      led_r <= '0;
    end else begin
      led_r <= led_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign active_group = active_r;
  assign edit_group = edit_r;
  assign aux_relay_sel = relay_r;
  assign grp_led = led_r;
  assign change_inhibited = inh_r;
  assign change_pending = pend_r;
  assign grp_event = evt_r;
  assign grp_event_group = evt_grp_r;

endmodule : setting_group_selector

// ### sgs_chk.sv
// Port checker for the setting group selector
`timescale 1ns/100ps

module sgs_chk #(
  parameter int NUM_GROUPS = 4,
  parameter int NUM_RELAYS = 5,
  parameter int NUM_OC = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Inputs
  input wire logic [2:0] cfg_edit_sel,
  input wire logic en_inh_oc,
  input wire logic [NUM_OC-1:0] oc_pickup,
  input wire logic [NUM_OC-1:0] oc_func_on,
  input wire logic [NUM_GROUPS-1:0][NUM_RELAYS-1:0] grp_relay_sel,
  // Outputs
  input wire logic [1:0] active_group,
  input wire logic [1:0] edit_group,
  input wire logic [NUM_RELAYS-1:0] aux_relay_sel,
  input wire logic [NUM_GROUPS-1:0] grp_led,
  input wire logic grp_event,
  input wire logic [1:0] grp_event_group
);
  logic [NUM_GROUPS-1:0][NUM_RELAYS-1:0] sel_r;
  logic oc_inh;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Element with a live function counts even if it never trips
  assign oc_inh = en_inh_oc && (|(oc_pickup & oc_func_on));

  // Relay table as seen at the previous edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_r <= '0;
    end else begin
      sel_r <= grp_relay_sel;
    end
  end

  led_active_a:
    assert property ($past(reset_n) |-> grp_led[active_group])
    else $error("active led off");
  led_spare_a:
    assert property ((grp_led & ~((4'h1 << active_group) |
      (4'h1 << edit_group))) == 4'h0)
    else $error("stray led on");
  edit_follow_a:
    assert property ($past(reset_n) && $past(cfg_edit_sel) >= 3'h4 |->
      edit_group == active_group)
    else $error("edit not following");
  edit_fixed_a:
    assert property ($past(reset_n) && $past(cfg_edit_sel) < 3'h4 |->
      {1'b0, edit_group} == $past(cfg_edit_sel))
    else $error("edit group wrong");
  relay_sel_a:
    assert property ($past(reset_n) |-> aux_relay_sel == sel_r[active_group])
    else $error("relay selection wrong");
  event_raise_a:
    assert property ($changed(active_group) && active_group != 2'h0 |->
      grp_event && grp_event_group == active_group)
    else $error("event missing");
  event_cause_a:
    assert property (grp_event |-> $changed(active_group))
    else $error("event without change");
  oc_freeze_a:
    assert property ($past(reset_n) && $past(oc_inh) |-> $stable(active_group))
    else $error("change while picked up");

  event_c: cover property (grp_event);
  oc_c: cover property (oc_inh);
  flash_c: cover property (edit_group != active_group && grp_led[edit_group]);
endmodule : sgs_chk

// Attach to the selector
bind setting_group_selector sgs_chk #(.NUM_GROUPS(NUM_GROUPS),
  .NUM_RELAYS(NUM_RELAYS), .NUM_OC(NUM_OC)) sgs_chk_inst (.clk(clk),
  .reset_n(reset_n), .cfg_edit_sel(cfg_edit_sel), .en_inh_oc(en_inh_oc),
  .oc_pickup(oc_pickup), .oc_func_on(oc_func_on),
  .grp_relay_sel(grp_relay_sel), .active_group(active_group),
  .edit_group(edit_group), .aux_relay_sel(aux_relay_sel),
  .grp_led(grp_led), .grp_event(grp_event),
  .grp_event_group(grp_event_group));

// ### sgs_field.sv
// Field side model: contacts, breaker status, element pickups
`timescale 1ns/100ps

module sgs_field (
  // Clock and commands
  input wire logic clk,
  input wire logic [3:0] want_grp,
  input wire logic [4:0] want_pick,
  input wire logic want_func,
  // Field signals
  output logic [3:0] grp_in_pin,
  output logic brk_open_pin,
  output logic [4:0] oc_pickup,
  output logic [4:0] oc_func_on,
  output logic ov_pickup,
  output logic ov_func_on,
  output logic uv_bus_pickup,
  output logic uv_bus_func_on,
  output logic uv_line_pickup,
  output logic uv_line_func_on,
  output logic uf_pickup,
  output logic uf_func_on
);
  // Levels held until commanded otherwise; reset covers the first edge
  always @(posedge clk) begin
    grp_in_pin <= want_grp;
    brk_open_pin <= want_pick[0];
    oc_pickup <= {want_pick[1], 4'h0};
    ov_pickup <= want_pick[2];
    uv_bus_pickup <= want_pick[3];
    uv_line_pickup <= want_pick[3];
    uf_pickup <= want_pick[4];
    {oc_func_on, ov_func_on, uv_bus_func_on} <= {7{want_func}};
    {uv_line_func_on, uf_func_on} <= {2{want_func}};
  end
endmodule : sgs_field

// ### testbench.sv
// Self-checking bench for the setting group selector
`timescale 1ns/100ps
`define CHK(a, e) check_val(32'(a), 32'(e))

module testbench;
  localparam int FH = 4;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [1:0] cfg_grp = 2'h0;
  logic [2:0] cfg_edit = 3'h4;
  logic [4:0] en = 5'h00;
  logic [3:0] want_grp = 4'h0;
  logic [4:0] want_pick = 5'h00;
  logic want_func = 1'b1;
  logic [3:0][4:0] rsel = {5'h11, 5'h0A, 5'h1F, 5'h03};
  logic [3:0] grp_in_pin, grp_led;
  logic [4:0] oc_pickup, oc_func_on, aux_relay_sel;
  logic [1:0] active_group, edit_group, grp_event_group;
  logic brk_open_pin, ov_pickup, ov_func_on, uv_bus_pickup, uv_bus_func_on;
  logic uv_line_pickup, uv_line_func_on, uf_pickup, uf_func_on;
  logic change_inhibited, change_pending, grp_event;
  int mismatches = 0;
  int check_count = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  sgs_field sgs_field_inst (.clk, .want_grp, .want_pick, .want_func,
    .grp_in_pin, .brk_open_pin, .oc_pickup, .oc_func_on, .ov_pickup,
    .ov_func_on, .uv_bus_pickup, .uv_bus_func_on, .uv_line_pickup,
    .uv_line_func_on, .uf_pickup, .uf_func_on);

  // Short flash half period keeps the flash test brief
  setting_group_selector #(.FLASH_HALF_CYC(FH)) setting_group_selector_inst (
    .clk, .reset_n, .clk_en, .cfg_active_group(cfg_grp),
    .cfg_edit_sel(cfg_edit), .en_inh_open_brk(en[0]), .en_inh_oc(en[1]),
    .en_inh_ov(en[2]), .en_inh_uv(en[3]), .en_inh_uf(en[4]), .grp_in_pin,
    .brk_open_pin, .oc_pickup, .oc_func_on, .ov_pickup, .ov_func_on,
    .uv_bus_pickup, .uv_bus_func_on, .uv_line_pickup, .uv_line_func_on,
    .uf_pickup, .uf_func_on, .grp_relay_sel(rsel), .active_group,
    .edit_group, .aux_relay_sel, .grp_led, .change_inhibited,
    .change_pending, .grp_event, .grp_event_group);

  task automatic check_val(input logic [31:0] a, input logic [31:0] e);
    check_count++;
    if (a !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : check_val

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // Bounded wait for the active group; running out ends the run
  task automatic wait_grp(input logic [1:0] g);
    int i;
    for (i = 0; i < 8 && active_group !== g; i++) tick(1);
    if (i == 8) begin
      mismatches++;
      results();
    end
    `CHK(active_group, g);
  endtask : wait_grp

  task automatic t_reset;
    tick(1);
    `CHK({active_group, edit_group, grp_event}, 5'h00);
    repeat (4 * FH) begin
      tick(1);
      `CHK(grp_led, 4'h1);
    end
  endtask : t_reset

  task automatic t_setting;
    for (int g = 0; g < 5; g++) begin
      @(posedge clk);
      cfg_grp <= 2'(g % 4);
      tick(1);
      `CHK(active_group, g % 4);
      `CHK(aux_relay_sel, rsel[g % 4]);
      `CHK(grp_event, g % 4 != 0);
      `CHK(grp_event_group, g == 4 ? 3 : g);
    end
  endtask : t_setting

  task automatic t_pins;
    @(posedge clk);
    want_grp <= 4'hE;
    wait_grp(2'h3);
    @(posedge clk);
    want_grp <= 4'h6;
    wait_grp(2'h2);
    @(posedge clk);
    cfg_grp <= 2'h3;
    wait_grp(2'h3);
    @(posedge clk);
    cfg_grp <= 2'h0;
    wait_grp(2'h2);
  endtask : t_pins

  task automatic t_edit;
    int on;
    @(posedge clk);
    cfg_edit <= 3'h2;
    want_grp <= 4'h2;
    wait_grp(2'h1);
    on = 0;
    repeat (4 * FH) begin
      tick(1);
      on += int'(grp_led[2] === 1'b1);
      `CHK(edit_group, 2'h2);
      `CHK(grp_led & 4'hB, 4'h2);
    end
    `CHK(on, 2 * FH);
    // Out-of-range edit codes must behave as follow-active
    @(posedge clk);
    cfg_edit <= 3'h7;
    want_grp <= 4'h0;
    wait_grp(2'h0);
    `CHK(edit_group, 2'h0);
  endtask : t_edit

  // One inhibit source against a setting change, then release
  task automatic t_inh(input int s, input logic e, input logic f);
    logic blk;
    blk = e && (f || s == 0);
    @(posedge clk);
    en <= e ? 5'h01 << s : 5'h00;
    want_pick <= 5'h01 << s;
    want_func <= f;
    tick(4);
    @(posedge clk);
    cfg_grp <= 2'h2;
    tick(4);
    `CHK(active_group, blk ? 0 : 2);
    `CHK({change_pending, change_inhibited}, {2{blk}});
    @(posedge clk);
    want_pick <= 5'h00;
    wait_grp(2'h2);
    @(posedge clk);
    cfg_grp <= 2'h0;
    wait_grp(2'h0);
  endtask : t_inh

  task automatic t_rerst;
    @(posedge clk);
    cfg_grp <= 2'h1;
    wait_grp(2'h1);
    @(posedge clk);
    reset_n <= 1'b0;
    tick(2);
    `CHK({active_group, grp_led, grp_event_group}, 8'h00);
    @(posedge clk);
    reset_n <= 1'b1;
    wait_grp(2'h1);
  endtask : t_rerst

  // Clock enable low freezes state; the change lands once it returns
  task automatic t_freeze;
    @(posedge clk);
    clk_en <= 1'b0;
    cfg_grp <= 2'h3;
    tick(4);
    `CHK(active_group, 2'h1);
    @(posedge clk);
    clk_en <= 1'b1;
    wait_grp(2'h3);
    @(posedge clk);
    cfg_grp <= 2'h1;
    wait_grp(2'h1);
  endtask : t_freeze

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_setting();
    t_pins();
    t_edit();
    t_inh(0, 1'b1, 1'b1);
    for (int s = 1; s < 5; s++) t_inh(s, 1'b1, 1'b1);
    t_inh(1, 1'b0, 1'b1);
    t_inh(2, 1'b1, 1'b0);
    t_rerst();
    t_freeze();
    results();
  end
endmodule : testbench
